// file: rtl/dcr_pkg.sv
// package for the dual channel converter configuration register bank
// assumes a single 200 MHz core clock; serial pins are asynchronous to it
package dcr_pkg;
  // ----------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] ADDR_ID = 8'h01;
  localparam logic [7:0] ADDR_GRADE = 8'h02;
  localparam logic [7:0] ADDR_CHAN_IDX = 8'h05;
  localparam logic [7:0] ADDR_XFER = 8'hFF;
  localparam logic [7:0] ADDR_FUNC_LO = 8'h08;
  localparam logic [7:0] ADDR_FUNC_HI = 8'h25;
  localparam logic [7:0] ADDR_SHADOW_HI = 8'h20;
  localparam logic [7:0] ADDR_DIG_LO = 8'h3A;
  localparam logic [7:0] ADDR_DIG_HI = 8'h3E;
  localparam logic [7:0] ADDR_LOCAL_PWR = 8'h08;
  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_CHAN_IDX = 8'h03;
  localparam logic [7:0] XFER_CMD = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int LSB_FIRST_HI = 6;
  localparam int LSB_FIRST_LO = 1;
  localparam int SOFT_RST_HI = 5;
  localparam int SOFT_RST_LO = 2;
  localparam int INSTR_BITS = 16;
  localparam int WORD_BITS = 8;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic [1:0] len;
    logic [12:0] addr;
  } dcr_instr_t;
  typedef struct packed {
    logic chanB;
    logic chanA;
  } dcr_sel_t;
endpackage

// file: rtl/dcr_config_bank.sv
// configuration register bank with a three-wire serial slave
// assumes serial pins are asynchronous and sampled on clk; sclk at most clk/8
`timescale 1ns/100ps
module dcr_config_bank #(
  parameter logic [7:0] ID_CODE = 8'h5A, // arbitrary value
  parameter logic [1:0] SPEED_GRADE = 2'h0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  // active configuration
  output logic [255:0][7:0] activeA,
  output logic [255:0][7:0] activeB
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclkS, csS, sdS;
  logic sclkD;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclkS <= 2'h0;
      csS <= 2'h3;
      sdS <= 2'h0;
      sclkD <= 1'b0;
    end
    else
    begin
      sclkS <= {sclkS[0], sclk};
      csS <= {csS[0], csN};
      sdS <= {sdS[0], sdioIn};
      sclkD <= sclkS[1];
    end
  end
  wire rise = sclkS[1] & ~sclkD;
  wire fall = ~sclkS[1] & sclkD;
  wire sel = ~csS[1];
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] portCfg, chanIdx;
  logic [255:0][7:0] shadowA, shadowB;
  logic softRst, lsbFirst;
  dcr_pkg::dcr_sel_t chSel;
  assign chSel = dcr_pkg::dcr_sel_t'(chanIdx[1:0]);
  assign lsbFirst = portCfg[dcr_pkg::LSB_FIRST_HI] | portCfg[dcr_pkg::LSB_FIRST_LO];
  assign softRst = portCfg[dcr_pkg::SOFT_RST_HI] | portCfg[dcr_pkg::SOFT_RST_LO];
  function automatic logic isFunc(input logic [7:0] a);
    isFunc = (a >= dcr_pkg::ADDR_FUNC_LO && a <= dcr_pkg::ADDR_FUNC_HI) ||
      (a >= dcr_pkg::ADDR_DIG_LO && a <= dcr_pkg::ADDR_DIG_HI);
  endfunction
  function automatic logic isShadow(input logic [7:0] a);
    isShadow = (a >= dcr_pkg::ADDR_FUNC_LO && a <= dcr_pkg::ADDR_SHADOW_HI) ||
      (a >= dcr_pkg::ADDR_DIG_LO && a <= dcr_pkg::ADDR_DIG_HI);
  endfunction
  // local set is kept small: only the power mode register is per channel
  function automatic logic isLocal(input logic [7:0] a);
    isLocal = (a == dcr_pkg::ADDR_LOCAL_PWR);
  endfunction
  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  logic [4:0] bitCnt;
  logic [15:0] sh, next_instr;
  logic inData;
  dcr_pkg::dcr_instr_t instr;
  logic [7:0] curAddr, rdByte, next_byte;
  logic wrStb;
  logic [7:0] wrAddr, wrData;
  wire shiftIn = rise & sel;
  // lsb-first frames arrive reversed: re-order the completed word
  function automatic logic [7:0] ord8(input logic [7:0] v, input logic lsb);
    ord8 = lsb ? {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]} : v;
  endfunction
  assign next_byte = ord8({sh[6:0], sdS[1]}, lsbFirst);
  assign next_instr = lsbFirst ? {ord8({sh[6:0], sdS[1]}, 1'b1), ord8(sh[14:7], 1'b1)} :
    {sh[14:0], sdS[1]};
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitCnt <= 5'h00;
      sh <= 16'h0000;
      inData <= 1'b0;
      instr <= '0;
      curAddr <= 8'h00;
      wrStb <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
    end
    else
    begin
      wrStb <= 1'b0;
      if (!sel)
      begin
        bitCnt <= 5'h00;
        inData <= 1'b0;
      end
      else if (shiftIn)
      begin
        sh <= {sh[14:0], sdS[1]};
        if (!inData && bitCnt == 5'(dcr_pkg::INSTR_BITS - 1))
        begin
          instr <= dcr_pkg::dcr_instr_t'(next_instr);
          curAddr <= next_instr[7:0];
          inData <= 1'b1;
          bitCnt <= 5'h00;
        end
        else if (inData && bitCnt == 5'(dcr_pkg::WORD_BITS - 1))
        begin
          bitCnt <= 5'h00;
          curAddr <= lsbFirst ? curAddr + 8'h01 : curAddr - 8'h01;
          if (!instr.rd)
          begin
            wrStb <= 1'b1;
            wrAddr <= curAddr;
            wrData <= next_byte;
          end
        end
        else
          bitCnt <= bitCnt + 5'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic xferPend;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      portCfg <= dcr_pkg::RST_PORT_CFG;
      chanIdx <= dcr_pkg::RST_CHAN_IDX;
      shadowA <= '0;
      shadowB <= '0;
      xferPend <= 1'b0;
    end
    else if (softRst)
    begin
      portCfg <= dcr_pkg::RST_PORT_CFG;
      chanIdx <= dcr_pkg::RST_CHAN_IDX;
      shadowA <= '0;
      shadowB <= '0;
      xferPend <= 1'b0;
    end
    else
    begin
      xferPend <= 1'b0;
      if (wrStb)
      begin
        if (wrAddr == dcr_pkg::ADDR_PORT_CFG)
          portCfg <= {1'b0, wrData[6:5], 2'h3, wrData[2:1], 1'b0};
        else if (wrAddr == dcr_pkg::ADDR_CHAN_IDX)
          chanIdx <= {6'h00, wrData[1:0]};
        else if (wrAddr == dcr_pkg::ADDR_XFER)
          xferPend <= wrData == dcr_pkg::XFER_CMD;
        else if (isFunc(wrAddr))
        begin
          if (!isLocal(wrAddr))
          begin
            shadowA[wrAddr] <= wrData;
            shadowB[wrAddr] <= wrData;
          end
          else
          begin
            if (chSel.chanA)
              shadowA[wrAddr] <= wrData;
            if (chSel.chanB)
              shadowB[wrAddr] <= wrData;
          end
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // active copy
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      activeA <= '0;
      activeB <= '0;
    end
    else if (softRst)
    begin
      activeA <= '0;
      activeB <= '0;
    end
    else
    begin
      for (int i = 0; i < 256; i++)
      begin
        if (!isShadow(8'(i)))
        begin
          activeA[i] <= shadowA[i];
          activeB[i] <= shadowB[i];
        end
        else if (xferPend)
        begin
          activeA[i] <= shadowA[i];
          activeB[i] <= shadowB[i];
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  always_comb
  begin
    rdByte = dcr_pkg::ZERO_BYTE;
    if (curAddr == dcr_pkg::ADDR_PORT_CFG)
      rdByte = portCfg;
    else if (curAddr == dcr_pkg::ADDR_ID)
      rdByte = ID_CODE;
    else if (curAddr == dcr_pkg::ADDR_GRADE)
      rdByte = {2'h0, SPEED_GRADE, 4'h0};
    else if (curAddr == dcr_pkg::ADDR_CHAN_IDX)
      rdByte = chanIdx;
    else if (isFunc(curAddr))
      rdByte = (chSel.chanA || !isLocal(curAddr)) ? shadowA[curAddr] : shadowB[curAddr];
  end
  logic [7:0] outSh;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      outSh <= 8'h00;
      sdioOut <= 1'b0;
      sdioOe <= 1'b0;
    end
    else
    begin
      sdioOe <= sel & inData & instr.rd;
      if (!sel || !inData)
        outSh <= ord8(rdByte, lsbFirst);
      else if (fall && instr.rd)
      begin
        sdioOut <= outSh[7];
        outSh <= (bitCnt == 5'h00) ? {ord8(rdByte, lsbFirst)} << 1 : outSh << 1;
      end
      if (sel && inData && instr.rd && bitCnt == 5'h00 && fall)
        sdioOut <= 1'(ord8(rdByte, lsbFirst) >> 7);
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  xfer_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    xferPend |=> !xferPend) else $error("transfer bit did not clear");
  cfg_mirror_a: assert property (@(posedge clk) disable iff (!nrst)
    portCfg[6] == portCfg[1] || $past(wrStb)) else $error("port config not mirrored");
  shadow_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !$past(xferPend) && !$past(softRst) |-> $stable(activeA[dcr_pkg::ADDR_LOCAL_PWR]))
    else $error("shadowed register changed without transfer");
  sequence xfer_req_s;
    wrStb && !softRst && wrAddr == dcr_pkg::ADDR_XFER && wrData == dcr_pkg::XFER_CMD;
  endsequence
  xfer_seq_a: assert property (@(posedge clk) disable iff (!nrst)
    xfer_req_s |=> xferPend ##1 !xferPend) else $error("transfer command not applied");
  local_both_a: assert property (@(posedge clk) disable iff (!nrst)
    wrStb && !softRst && isLocal(wrAddr) && chSel.chanA && chSel.chanB |=>
    shadowA[wrAddr] == shadowB[wrAddr]) else $error("local write missed a channel");
  soft_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    softRst |=> portCfg == dcr_pkg::RST_PORT_CFG && chanIdx == dcr_pkg::RST_CHAN_IDX)
    else $error("soft reset did not restore defaults");
  read_dir_a: assert property (@(posedge clk) disable iff (!nrst)
    sdioOe |-> inData && instr.rd) else $error("data pin driven outside a read");
endmodule

// file: testbench/dcr_host.sv
// host controller model for the three-wire configuration port
// assumes clk is the core clock; sclk is made at clk/12, well inside clk/8
`timescale 1ns/100ps
module dcr_host (
  // clock
  input wire logic clk,
  // serial pins
  output logic sclk,
  output logic csN,
  output logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe
);
  // ----------------------------------------------------------------
  // line state
  // ----------------------------------------------------------------
  localparam int HALF = 6;
  logic lsbFirst = 1'b0;
  logic hostOe = 1'b0;
  logic hostBit = 1'b0;
  // released line shows the inverse so a stale bit never passes as data
  assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : ~hostBit);
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
  end
  // ----------------------------------------------------------------
  // frame tasks
  // ----------------------------------------------------------------
  task automatic shiftBit(input logic b, input logic rdPhase, output logic got);
    hostBit <= b;
    hostOe <= ~rdPhase;
    repeat (HALF) @(posedge clk);
    got = sdioOut;
    sclk <= 1'b1;
    repeat (HALF) @(posedge clk);
    sclk <= 1'b0;
  endtask
  // one byte per frame; only supported addresses, unused bits zero
  task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
    dcr_pkg::dcr_instr_t ins;
    logic g;
    int k;
    ins = '{rd, 2'h0, {5'h00, addr}};
    csN <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 0; i < 16; i++)
    begin
      k = lsbFirst ? i : 15 - i;
      shiftBit(ins[k], 1'b0, g);
    end
    for (int i = 0; i < 8; i++)
    begin
      k = lsbFirst ? i : 7 - i;
      shiftBit(wdat[k], rd, g);
      rdat[k] = g;
    end
    hostOe <= 1'b0;
    csN <= 1'b1;
    repeat (3 * HALF) @(posedge clk);
  endtask
endmodule

// file: testbench/dcr_config_bank_tb.sv
// testbench for the configuration register bank
// assumes the host model frames one byte per access
`timescale 1ns/100ps
module dcr_config_bank_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [7:0] ID = 8'hC3; // arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, csN, sdioIn, sdioOut, sdioOe;
  logic [255:0][7:0] activeA, activeB;
  logic [7:0] rd;
  int fail_count = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  dcr_config_bank #(.ID_CODE(ID), .SPEED_GRADE(2'h2)) u_dut (
    .clk(clk), .nrst(nrst), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe), .activeA(activeA), .activeB(activeB));
  dcr_host u_host (.clk(clk), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b0, a, d, rd);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.access(1'b1, a, 8'h00, rd);
    check($sformatf("reg %h", a), exp, rd);
  endtask
  task automatic results;
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(8'h00, 8'h18);
    rdchk(8'h05, 8'h03);
    rdchk(8'hFF, 8'h00);
    rdchk(8'h02, 8'h20);
    rdchk(8'h01, ID);
    rdchk(8'h03, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h10);
    rdchk(8'h01, ID);
    rdchk(8'h02, 8'h20);
    // a-only selection, then a global write that must reach both
    wr(8'h05, 8'h01);
    wr(8'h08, 8'h02);
    wr(8'h09, 8'h01);
    check("activeA 08", 8'h00, activeA[8]);
    check("activeA 09", 8'h00, activeA[9]);
    wr(8'h05, 8'h02);
    wr(8'h08, 8'h01);
    wr(8'hFF, 8'h01);
    check("activeA 08", 8'h02, activeA[8]);
    check("activeB 08", 8'h01, activeB[8]);
    check("activeA 09", 8'h01, activeA[9]);
    check("activeB 09", 8'h01, activeB[9]);
    rdchk(8'hFF, 8'h00);
    wr(8'h05, 8'h03);
    wr(8'h08, 8'h20);
    wr(8'hFF, 8'h01);
    check("activeA 08", 8'h20, activeA[8]);
    check("activeB 08", 8'h20, activeB[8]);
    wr(8'h05, 8'h01);
    wr(8'h08, 8'h22);
    wr(8'hFF, 8'h01);
    wr(8'h05, 8'h03);
    rdchk(8'h08, 8'h22);
    wr(8'h05, 8'h02);
    rdchk(8'h08, 8'h20);
    // both mirrored patterns read the same in either shift order
    wr(8'h00, 8'h5A);
    u_host.lsbFirst = 1'b1;
    rdchk(8'h00, 8'h5A);
    wr(8'h00, 8'h18);
    u_host.lsbFirst = 1'b0;
    rdchk(8'h00, 8'h18);
    wr(8'h05, 8'h01);
    wr(8'h00, 8'h3C);
    rdchk(8'h05, 8'h03);
    rdchk(8'h00, 8'h18);
    check("activeA 08", 8'h00, activeA[8]);
    check("activeB 09", 8'h00, activeB[9]);
    results();
  end
endmodule
